// file: adp_cfg.svh
// Constants for the ADC decimation and processing-block select logic.
// Assumes inclusion by adp_decim_proc.sv only; adp_pkg.sv does not include it.
`ifndef ADP_CFG_SVH
`define ADP_CFG_SVH
`define ADP_SAMPLE_W 16
`define ADP_FRAC 15
`define ADP_UNITY 16'h7FFF
`define ADP_COEF_WORDS 64
`define ADP_BANK_MASK 6'h1F
`define ADP_CH_BASE_L 6'h04
`define ADP_CH_BASE_R 6'h24
`define ADP_STAGE_OFS 6'h03
`define ADP_BQ_STRIDE 6'h05
`define ADP_BQ_AC 3'h5
`define ADP_BQ_B 3'h3
`define ADP_BQ_MAX 5
`define ADP_FIR_AC 5'h19
`define ADP_FIR_B 5'h14
`define ADP_FIR_MAX 25
`define ADP_OSR_128 8'h80
`define ADP_OSR_64 8'h40
`define ADP_OSR_32 8'h20
`define ADP_SH_128 5'h07
`define ADP_SH_64 5'h06
`define ADP_SH_32 5'h05
`define ADP_BLK_STEREO_BIQUAD_A 5'h02
`define ADP_BLK_STEREO_FIR_A 5'h03
`define ADP_BLK_RIGHT_BASIC_A 5'h04
`define ADP_BLK_STEREO_FIR_B 5'h09
`endif

// file: adp_pkg.sv
// Types for the ADC decimation and processing-block select logic.
// Assumes nothing from adp_cfg.svh; it includes no file.
`default_nettype none
package adp_pkg;
  typedef enum logic [2:0] {
    ADP_FILT_A = 3'b001,
    ADP_FILT_B = 3'b010,
    ADP_FILT_C = 3'b100
  } adp_filt_t;

  typedef enum logic [4:0] {
    ADP_ST_IDLE = 5'b00001,
    ADP_ST_IIR = 5'b00010,
    ADP_ST_BQ = 5'b00100,
    ADP_ST_FIR = 5'b01000,
    ADP_ST_OUT = 5'b10000
  } adp_state_t;

  typedef struct packed {
    logic valid;
    adp_filt_t filt;
    logic stereo;
    logic [2:0] nbq;
    logic [4:0] taps;
    logic [7:0] instr;
  } adp_blk_t;
endpackage
`default_nettype wire

// file: adp_decim_proc.sv
// Decimation filter and selectable processing block for a stereo audio ADC.
// Assumes modulator words arrive with a one-cycle valid strobe at the modulator rate.
//
// Behaviour
// - Three decimation filter types A, B, C with differing response and delay.
// - Modulator stream is accumulated and dumped at the Nyquist output rate.
// - Selected block fixes processing stages and decimation filter type.
// - Biquad blocks run five sections with A or C, three with B.
// - FIR blocks run 25 taps with A or C, 20 with B; never with biquads.
// - Every block has a first-order IIR; all coefficients user programmable.
// - Right-only blocks process right channel; stereo blocks both; fixed instruction count.
// - Each coefficient is 16-bit two's complement held in two byte registers.
`include "adp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module adp_decim_proc #(
  parameter int MOD_W = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Configuration
  input wire logic adc_power_in,
  input wire logic [4:0] block_select_in,
  input wire logic [7:0] adc_oversampling_ratio_in,
  // Coefficient byte writes
  input wire logic coef_wr_in,
  input wire logic [6:0] coef_addr_in,
  input wire logic [7:0] coef_data_in,
  // Modulator stream
  input wire logic mod_valid_in,
  input wire logic signed [MOD_W-1:0] mod_right_in,
  input wire logic signed [MOD_W-1:0] mod_left_in,
  // Output samples and status
  output logic sample_valid_out,
  output logic signed [15:0] sample_right_out,
  output logic signed [15:0] sample_left_out,
  output logic config_ok_out,
  output adp_pkg::adp_filt_t filter_type_out,
  output logic stereo_out,
  output logic [7:0] instr_count_out
);
  import adp_pkg::*;

  // ****************************************
  // Block table
  // ****************************************
  function automatic adp_blk_t blk_info(input logic [4:0] idx);
    adp_blk_t b;
    b = '0;
    unique case (idx)
      5'h01: b = '{1'b1, ADP_FILT_A, 1'b1, 3'h0, 5'h00, 8'hBC};
      `ADP_BLK_STEREO_BIQUAD_A: b = '{1'b1, ADP_FILT_A, 1'b1, `ADP_BQ_AC, 5'h00, 8'hF0};
      `ADP_BLK_STEREO_FIR_A: b = '{1'b1, ADP_FILT_A, 1'b1, 3'h0, `ADP_FIR_AC, 8'hEC};
      `ADP_BLK_RIGHT_BASIC_A: b = '{1'b1, ADP_FILT_A, 1'b0, 3'h0, 5'h00, 8'h60};
      5'h05: b = '{1'b1, ADP_FILT_A, 1'b0, `ADP_BQ_AC, 5'h00, 8'h78};
      5'h06: b = '{1'b1, ADP_FILT_A, 1'b0, 3'h0, `ADP_FIR_AC, 8'h78};
      5'h07: b = '{1'b1, ADP_FILT_B, 1'b1, 3'h0, 5'h00, 8'h58};
      5'h08: b = '{1'b1, ADP_FILT_B, 1'b1, `ADP_BQ_B, 5'h00, 8'h78};
      `ADP_BLK_STEREO_FIR_B: b = '{1'b1, ADP_FILT_B, 1'b1, 3'h0, `ADP_FIR_B, 8'h80};
      5'h0A: b = '{1'b1, ADP_FILT_B, 1'b0, 3'h0, 5'h00, 8'h2E};
      5'h0B: b = '{1'b1, ADP_FILT_B, 1'b0, `ADP_BQ_B, 5'h00, 8'h3C};
      5'h0C: b = '{1'b1, ADP_FILT_B, 1'b0, 3'h0, `ADP_FIR_B, 8'h40};
      5'h0D: b = '{1'b1, ADP_FILT_C, 1'b0, 3'h0, 5'h00, 8'h46};
      5'h0E: b = '{1'b1, ADP_FILT_C, 1'b1, `ADP_BQ_AC, 5'h00, 8'h7C};
      5'h0F: b = '{1'b1, ADP_FILT_C, 1'b1, 3'h0, `ADP_FIR_AC, 8'h78};
      5'h10: b = '{1'b1, ADP_FILT_C, 1'b0, 3'h0, 5'h00, 8'h24};
      5'h11: b = '{1'b1, ADP_FILT_C, 1'b0, `ADP_BQ_AC, 5'h00, 8'h40};
      5'h12: b = '{1'b1, ADP_FILT_C, 1'b0, 3'h0, `ADP_FIR_AC, 8'h3E};
      default: b = '0;
    endcase
    return b;
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [39:0] a);
    logic signed [39:0] s;
    s = a >>> `ADP_FRAC;
    if (s > 40'sh0000007FFF) return 16'sh7FFF;
    if (s < 40'shFFFFFF8000) return 16'sh8000;
    return s[15:0];
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [4:0] blk_reg, blk_next;
  logic [7:0] osr_reg, osr_next;
  adp_blk_t info;
  logic osr_ok;
  logic [4:0] sh;
  logic signed [MOD_W+7:0] acc_r_reg, acc_r_next, acc_l_reg, acc_l_next;
  logic [7:0] cnt_reg, cnt_next;
  logic signed [15:0] p1_reg [2], p2_reg [2], p1_next [2], p2_next [2];
  logic signed [15:0] dec_l_reg, dec_l_next;
  adp_state_t st_reg, st_next;
  logic ch_reg, ch_next;
  logic [2:0] sec_reg, sec_next;
  logic signed [15:0] val_reg, val_next, res_r_reg, res_r_next, res_l_reg, res_l_next;
  logic vld_next;
  logic signed [15:0] coef_mem [`ADP_COEF_WORDS];
  logic signed [15:0] iir_x1 [2], iir_y1 [2];
  logic signed [15:0] bq_x1 [2][`ADP_BQ_MAX], bq_x2 [2][`ADP_BQ_MAX];
  logic signed [15:0] bq_y1 [2][`ADP_BQ_MAX], bq_y2 [2][`ADP_BQ_MAX];
  logic signed [15:0] fir_hist [2][`ADP_FIR_MAX-1];
  logic [5:0] cbase, bqi;
  logic signed [15:0] iir_y, bq_y, dec_r, dec_l;
  logic signed [39:0] fir_sum [`ADP_FIR_MAX+1];

  assign info = blk_info(blk_reg);
  always_comb begin
    unique case (info.filt)
      ADP_FILT_A: osr_ok = osr_reg == `ADP_OSR_128 || osr_reg == `ADP_OSR_64;
      ADP_FILT_B: osr_ok = osr_reg == `ADP_OSR_64;
      ADP_FILT_C: osr_ok = osr_reg == `ADP_OSR_32;
      default: osr_ok = 1'b0;
    endcase
    unique case (osr_reg)
      `ADP_OSR_128: sh = `ADP_SH_128;
      `ADP_OSR_64: sh = `ADP_SH_64;
      default: sh = `ADP_SH_32;
    endcase
  end

  // ****************************************
  // Filter arithmetic
  // ****************************************
  assign cbase = ch_reg ? `ADP_CH_BASE_R : `ADP_CH_BASE_L;
  assign bqi = 6'(cbase + `ADP_STAGE_OFS + 6'(`ADP_BQ_STRIDE * sec_reg));
  assign iir_y = sat16(40'(coef_mem[cbase] * val_reg)
    + 40'(coef_mem[6'(cbase + 6'h01)] * iir_x1[ch_reg])
    + 40'(coef_mem[6'(cbase + 6'h02)] * iir_y1[ch_reg]));
  assign bq_y = sat16(40'(coef_mem[bqi] * val_reg)
    + 40'(coef_mem[6'(bqi + 6'h01)] * bq_x1[ch_reg][sec_reg]) * 2
    + 40'(coef_mem[6'(bqi + 6'h02)] * bq_x2[ch_reg][sec_reg])
    + 40'(coef_mem[6'(bqi + 6'h03)] * bq_y1[ch_reg][sec_reg]) * 2
    + 40'(coef_mem[6'(bqi + 6'h04)] * bq_y2[ch_reg][sec_reg]));

  // One multiplier per tap keeps the whole FIR to one cycle per channel
  assign fir_sum[0] = '0;
  for (genvar i = 0; i < `ADP_FIR_MAX; i++) begin : g_tap
    logic signed [15:0] tap;
    if (i == 0) begin : g_new
      assign tap = val_reg;
    end else begin : g_old
      assign tap = fir_hist[ch_reg][i-1];
    end
    assign fir_sum[i+1] = fir_sum[i] + ((5'(i) < info.taps)
      ? 40'(coef_mem[6'(cbase + `ADP_STAGE_OFS + 6'(i))] * tap) : 40'sh0);
  end

  // Decimator dump value: boxcar sum scaled, then per-type smoothing
  // Type and shift come in as arguments so the assigns below follow a block change
  function automatic logic signed [15:0] shape(input logic signed [MOD_W+7:0] s,
      input logic signed [15:0] q1, input logic signed [15:0] q2, input adp_filt_t ft,
      input logic [4:0] k);
    logic signed [39:0] w;
    w = (40'(s) <<< (16 - MOD_W)) >>> k;
    unique case (ft)
      ADP_FILT_A: w = (w + 40'(q1)) >>> 1;
      ADP_FILT_B: w = (w + 40'(q1) * 2 + 40'(q2)) >>> 2;
      default: w = w;
    endcase
    return w[15:0];
  endfunction
  assign dec_r = shape(acc_r_reg + mod_right_in, p1_reg[1], p2_reg[1], info.filt, sh);
  assign dec_l = shape(acc_l_reg + mod_left_in, p1_reg[0], p2_reg[0], info.filt, sh);

  // ****************************************
  // Control next state
  // ****************************************
  always_comb begin
    blk_next = blk_reg;
    osr_next = osr_reg;
    acc_r_next = acc_r_reg;
    acc_l_next = acc_l_reg;
    cnt_next = cnt_reg;
    p1_next = p1_reg;
    p2_next = p2_reg;
    dec_l_next = dec_l_reg;
    st_next = st_reg;
    ch_next = ch_reg;
    sec_next = sec_reg;
    val_next = val_reg;
    res_r_next = res_r_reg;
    res_l_next = res_l_reg;
    vld_next = 1'b0;
    if (!adc_power_in) begin
      blk_next = block_select_in;
      osr_next = adc_oversampling_ratio_in;
      acc_r_next = '0;
      acc_l_next = '0;
      cnt_next = '0;
    end else if (mod_valid_in && info.valid && osr_ok) begin
      if (cnt_reg == 8'(osr_reg - 8'h01)) begin
        acc_r_next = '0;
        acc_l_next = '0;
        cnt_next = '0;
        p1_next = '{dec_l, dec_r};
        p2_next = p1_reg;
        if (st_reg == ADP_ST_IDLE) begin
          dec_l_next = dec_l;
          val_next = dec_r;
          ch_next = 1'b1;
          st_next = ADP_ST_IIR;
        end
      end else begin
        acc_r_next = acc_r_reg + mod_right_in;
        acc_l_next = acc_l_reg + mod_left_in;
        cnt_next = 8'(cnt_reg + 8'h01);
      end
    end
    unique case (st_reg)
      ADP_ST_IDLE: ;
      ADP_ST_IIR: begin
        val_next = iir_y;
        sec_next = '0;
        st_next = info.nbq != 3'h0 ? ADP_ST_BQ
          : info.taps != 5'h00 ? ADP_ST_FIR : ADP_ST_OUT;
      end
      ADP_ST_BQ: begin
        val_next = bq_y;
        sec_next = 3'(sec_reg + 3'h1);
        if (sec_reg == 3'(info.nbq - 3'h1)) st_next = ADP_ST_OUT;
      end
      ADP_ST_FIR: begin
        val_next = sat16(fir_sum[`ADP_FIR_MAX]);
        st_next = ADP_ST_OUT;
      end
      ADP_ST_OUT: begin
        if (ch_reg) res_r_next = val_reg;
        else res_l_next = val_reg;
        if (ch_reg && info.stereo) begin
          ch_next = 1'b0;
          val_next = dec_l_reg;
          st_next = ADP_ST_IIR;
        end else begin
          if (!info.stereo) res_l_next = '0;
          vld_next = 1'b1;
          st_next = ADP_ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      blk_reg <= `ADP_BLK_RIGHT_BASIC_A;
      osr_reg <= `ADP_OSR_128;
      acc_r_reg <= '0;
      acc_l_reg <= '0;
      cnt_reg <= '0;
      p1_reg <= '{default: '0};
      p2_reg <= '{default: '0};
      dec_l_reg <= '0;
      st_reg <= ADP_ST_IDLE;
      ch_reg <= 1'b1;
      sec_reg <= '0;
      val_reg <= '0;
      res_r_reg <= '0;
      res_l_reg <= '0;
      sample_valid_out <= 1'b0;
      sample_right_out <= '0;
      sample_left_out <= '0;
    end else begin
      blk_reg <= blk_next;
      osr_reg <= osr_next;
      acc_r_reg <= acc_r_next;
      acc_l_reg <= acc_l_next;
      cnt_reg <= cnt_next;
      p1_reg <= p1_next;
      p2_reg <= p2_next;
      dec_l_reg <= dec_l_next;
      st_reg <= st_next;
      ch_reg <= ch_next;
      sec_reg <= sec_next;
      val_reg <= val_next;
      res_r_reg <= res_r_next;
      res_l_reg <= res_l_next;
      sample_valid_out <= vld_next;
      if (vld_next) begin
        sample_right_out <= res_r_next;
        sample_left_out <= res_l_next;
      end
    end
  end

  // Coefficients and filter histories; defaults give a flat 0 dB path except in FIR blocks, where taps 0, 5, 10, 15 and 20 default to unity
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < `ADP_COEF_WORDS; i++) begin
        coef_mem[i] <= ((6'(i) & `ADP_BANK_MASK) == `ADP_CH_BASE_L
          || ((6'(i) & `ADP_BANK_MASK) >= 6'h07
          && ((6'(i) & `ADP_BANK_MASK) - 6'h07) % `ADP_BQ_STRIDE == 6'h00))
          ? `ADP_UNITY : 16'h0000;
      end
      iir_x1 <= '{default: '0};
      iir_y1 <= '{default: '0};
      bq_x1 <= '{default: '{default: '0}};
      bq_x2 <= '{default: '{default: '0}};
      bq_y1 <= '{default: '{default: '0}};
      bq_y2 <= '{default: '{default: '0}};
      fir_hist <= '{default: '{default: '0}};
    end else begin
      if (coef_wr_in) begin
        if (coef_addr_in[0]) coef_mem[coef_addr_in[6:1]][7:0] <= coef_data_in;
        else coef_mem[coef_addr_in[6:1]][15:8] <= coef_data_in;
      end
      if (st_reg == ADP_ST_IIR) begin
        iir_x1[ch_reg] <= val_reg;
        iir_y1[ch_reg] <= iir_y;
      end
      if (st_reg == ADP_ST_BQ) begin
        bq_x1[ch_reg][sec_reg] <= val_reg;
        bq_x2[ch_reg][sec_reg] <= bq_x1[ch_reg][sec_reg];
        bq_y1[ch_reg][sec_reg] <= bq_y;
        bq_y2[ch_reg][sec_reg] <= bq_y1[ch_reg][sec_reg];
      end
      if (st_reg == ADP_ST_FIR) begin
        fir_hist[ch_reg][0] <= val_reg;
        for (int i = 1; i < `ADP_FIR_MAX - 1; i++) fir_hist[ch_reg][i] <= fir_hist[ch_reg][i-1];
      end
    end
  end

  // ****************************************
  // Status
  // ****************************************
  assign config_ok_out = info.valid && osr_ok;
  assign filter_type_out = info.filt;
  assign stereo_out = info.stereo;
  assign instr_count_out = info.instr;
endmodule
`default_nettype wire

// file: adp_chk.sv
// Port checker for adp_decim_proc.
// Assumes it is bound to the adp_decim_proc instance of the bench.
`timescale 1ns/100ps
`default_nettype none
module adp_chk (
  // Clock, reset and configuration
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic adc_power_in,
  input wire logic [4:0] block_select_in,
  input wire logic [7:0] adc_oversampling_ratio_in,
  // Results and status
  input wire logic sample_valid_out,
  input wire logic signed [15:0] sample_left_out,
  input wire logic config_ok_out,
  input wire adp_pkg::adp_filt_t filter_type_out,
  input wire logic stereo_out,
  input wire logic [7:0] instr_count_out
);
  import adp_pkg::*;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // ******
  // Properties
  // ******
  sequence s_load(logic [4:0] b);
    !adc_power_in && block_select_in == b ##1 1'b1;
  endsequence
  // Sixteen quiet cycles outlast the longest engine pass
  sequence s_quiet;
    !config_ok_out [*8];
  endsequence
  property p_hold;
    adc_power_in && $past(adc_power_in) |->
      $stable({config_ok_out, filter_type_out, stereo_out, instr_count_out});
  endproperty
  property p_ratio;
    !adc_power_in ##1 filter_type_out != 3'h0 |-> config_ok_out ==
      ((filter_type_out == ADP_FILT_A) ? ($past(adc_oversampling_ratio_in) inside {8'h80, 8'h40}) :
      ($past(adc_oversampling_ratio_in) == ((filter_type_out == ADP_FILT_B) ? 8'h40 : 8'h20)));
  endproperty
  property p_bad;
    filter_type_out == 3'h0 |-> !config_ok_out && !stereo_out && instr_count_out == 8'h00;
  endproperty
  property p_onehot;
    config_ok_out |-> $onehot(filter_type_out);
  endproperty
  property p_blk4;
    s_load(5'h04) |-> filter_type_out == ADP_FILT_A && !stereo_out && instr_count_out == 8'h60;
  endproperty
  property p_blk9;
    s_load(5'h09) |-> filter_type_out == ADP_FILT_B && stereo_out && instr_count_out == 8'h80;
  endproperty
  property p_pulse;
    sample_valid_out |=> !sample_valid_out;
  endproperty
  property p_left;
    sample_valid_out && !stereo_out |-> sample_left_out == 16'sh0000;
  endproperty
  property p_quiet;
    s_quiet ##1 s_quiet |=> !sample_valid_out;
  endproperty
  a_hold: assert property (p_hold) else $error("status moved while powered");
  a_ratio: assert property (p_ratio) else $error("ratio fit wrong");
  a_bad: assert property (p_bad) else $error("invalid block status");
  a_onehot: assert property (p_onehot) else $error("filter type not one-hot");
  a_blk4: assert property (p_blk4) else $error("basic right block status");
  a_blk9: assert property (p_blk9) else $error("fir b block status");
  a_pulse: assert property (p_pulse) else $error("valid longer than one cycle");
  a_left: assert property (p_left) else $error("left not zero");
  a_quiet: assert property (p_quiet) else $error("sample while refused");
endmodule
bind adp_decim_proc adp_chk u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .adc_power_in(adc_power_in),
  .block_select_in(block_select_in), .adc_oversampling_ratio_in(adc_oversampling_ratio_in),
  .sample_valid_out(sample_valid_out), .sample_left_out(sample_left_out),
  .config_ok_out(config_ok_out), .filter_type_out(filter_type_out),
  .stereo_out(stereo_out), .instr_count_out(instr_count_out)
);
`default_nettype wire

// file: adp_mod_src.sv
// Modulator model: one word pair every second cycle while running.
// Assumes the bench holds run_in and the levels steady during a run.
`timescale 1ns/100ps
`default_nettype none
module adp_mod_src (
  // Clock and control
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic signed [3:0] right_in,
  input wire logic signed [3:0] left_in,
  // Modulator stream
  output logic mod_valid_out,
  output logic signed [3:0] mod_right_out,
  output logic signed [3:0] mod_left_out
);
  logic phase_reg;
  initial {phase_reg, mod_valid_out, mod_right_out, mod_left_out} = '0;
  // ******
  // Stream
  // ******
  // Gap cycles keep dumps far apart; idle words are inverted, not held
  always @(negedge clk_in) begin
    phase_reg <= run_in & ~phase_reg;
    mod_valid_out <= run_in & ~phase_reg;
    mod_right_out <= (run_in & ~phase_reg) ? right_in : ~right_in;
    mod_left_out <= (run_in & ~phase_reg) ? left_in : ~left_in;
  end
endmodule
`default_nettype wire

// file: testbench.sv
// Bench for adp_decim_proc with an integer model of each block.
// Assumes adp_chk is bound and adp_mod_src drives the modulator pins.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import adp_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic adc_power_in = 1'b1;
  logic [4:0] block_select_in = 5'h00;
  logic [7:0] adc_oversampling_ratio_in = 8'h80;
  logic coef_wr_in = 1'b0;
  logic [6:0] coef_addr_in = 7'h00;
  logic [7:0] coef_data_in = 8'h00;
  logic run_src = 1'b0;
  logic signed [3:0] src_r = 4'h0;
  logic signed [3:0] src_l = 4'h0;
  wire logic mod_valid;
  wire logic signed [3:0] mod_r;
  wire logic signed [3:0] mod_l;
  logic sample_valid, config_ok, stereo;
  logic signed [15:0] smp_r, smp_l;
  adp_filt_t filt;
  logic [7:0] instr;
  wire logic [12:0] stat = {config_ok, filt, stereo, instr};
  int n_mismatch = 0;
  int n_compared = 0;
  int n_valid = 0;
  int instr_t[18] = '{188, 240, 236, 96, 120, 120, 88, 120, 128, 46, 60, 64, 70, 124, 120, 36,
    64, 62};
  logic [17:0] st_t = 18'h061C7;
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) if (sample_valid === 1'b1) n_valid <= n_valid + 1;
  adp_mod_src src (.clk_in(clk_in), .run_in(run_src), .right_in(src_r), .left_in(src_l),
    .mod_valid_out(mod_valid), .mod_right_out(mod_r), .mod_left_out(mod_l));
  adp_decim_proc uut (.clk_in(clk_in), .reset_in(reset_in), .adc_power_in(adc_power_in),
    .block_select_in(block_select_in), .adc_oversampling_ratio_in(adc_oversampling_ratio_in),
    .coef_wr_in(coef_wr_in), .coef_addr_in(coef_addr_in), .coef_data_in(coef_data_in),
    .mod_valid_in(mod_valid), .mod_right_in(mod_r), .mod_left_in(mod_l),
    .sample_valid_out(sample_valid), .sample_right_out(smp_r), .sample_left_out(smp_l),
    .config_ok_out(config_ok), .filter_type_out(filt), .stereo_out(stereo),
    .instr_count_out(instr));
  // ******
  // Model and tasks
  // ******
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_cfg(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t status %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_smp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t sample %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [12:0] exp_cfg(input int b, input int r);
    int f;
    logic ok;
    if (b < 1 || b > 18) return 13'h0000;
    f = (b - 1) / 6;
    ok = (f == 0) ? (r != 8'h20) : (r == ((f == 1) ? 8'h40 : 8'h20));
    return {ok, 3'(1 << f), st_t[b - 1], 8'(instr_t[b - 1])};
  endfunction
  // Smoother states and FIR histories per channel; both live on across runs
  int q1[2], q2[2];
  int fh[2][25];
  task automatic mdl(input int f, input int nbq, input int taps, input int ch, input int v,
      input bit on, output int y);
    longint s;
    y = v * 4096;
    if (f == 0) y = (y + q1[ch]) >>> 1;
    else if (f == 1) y = (y + 2 * q1[ch] + q2[ch]) >>> 2;
    q2[ch] = q1[ch];
    q1[ch] = y;
    s = 0;
    if (on) begin
      y = (y * 32767) >>> 15;
      repeat (nbq) y = (y * 32767) >>> 15;
      if (taps != 0) begin
        for (int i = 24; i > 0; i--) fh[ch][i] = fh[ch][i - 1];
        fh[ch][0] = y;
        for (int i = 0; i < taps; i++) begin
          s += longint'(fh[ch][i])
            * ((i == 19) ? 16384 : (i == 20) ? 8192 : (i == 24) ? 4096 : 0);
        end
        y = int'(s >>> 15);
      end
    end else y = 0;
  endtask
  task automatic cfg(input int b, input int r);
    @(negedge clk_in);
    adc_power_in = 1'b0;
    block_select_in = 5'(b);
    adc_oversampling_ratio_in = 8'(r);
    @(negedge clk_in);
    adc_power_in = 1'b1;
    block_select_in = 5'($urandom);
    adc_oversampling_ratio_in = 8'($urandom);
  endtask
  task automatic wcoef(input int w, input logic [15:0] c);
    @(negedge clk_in);
    coef_wr_in = 1'b1;
    coef_addr_in = 7'(2 * w);
    coef_data_in = c[15:8];
    @(negedge clk_in);
    coef_addr_in = 7'(2 * w + 1);
    coef_data_in = c[7:0];
  endtask
  task automatic run(input int b, input int r);
    int f, k, nbq, taps, er, el, t;
    f = (b - 1) / 6;
    k = (b - 1) % 3;
    nbq = (k == 1) ? ((f == 1) ? 3 : 5) : 0;
    taps = (k == 2) ? ((f == 1) ? 20 : 25) : 0;
    src_r = 4'($urandom);
    src_l = 4'($urandom);
    cfg(b, r);
    run_src = 1'b1;
    for (int n = 0; n < taps + 6; n++) begin
      t = 0;
      do begin
        @(negedge clk_in);
        t++;
      end while (sample_valid !== 1'b1 && t < 600);
      if (t >= 600) chk_smp(16'hDEAD, 16'h0000);
      mdl(f, nbq, taps, 1, src_r, 1'b1, er);
      mdl(f, nbq, taps, 0, src_l, st_t[b - 1], el);
      chk_smp(smp_r, 16'(er));
      chk_smp(smp_l, 16'(el));
    end
    run_src = 1'b0;
  endtask
  // ******
  // Sequence
  // ******
  initial begin
    int rs[3] = '{8'h80, 8'h40, 8'h20};
    int rb[8] = '{5'h04, 5'h02, 5'h08, 5'h11, 5'h0D, 5'h09, 5'h0F, 5'h06};
    int rr[8] = '{8'h40, 8'h80, 8'h40, 8'h20, 8'h20, 8'h40, 8'h20, 8'h80};
    int nv;
    void'($urandom(26710));
    repeat (20) @(negedge clk_in);
    reset_in = 1'b0;
    @(negedge clk_in);
    chk_cfg(stat, exp_cfg(4, 8'h80));
    for (int b = 0; b < 20; b++) begin
      foreach (rs[i]) begin
        cfg(b, rs[i]);
        chk_cfg(stat, exp_cfg(b, rs[i]));
        @(negedge clk_in);
        chk_cfg(stat, exp_cfg(b, rs[i]));
      end
    end
    cfg(4, 8'h20);
    nv = n_valid;
    run_src = 1'b1;
    repeat (400) @(negedge clk_in);
    run_src = 1'b0;
    chk_smp(16'(n_valid - nv), 16'h0000);
    foreach (rb[i]) begin
      // Taps share words with biquads, so they are loaded only after biquad runs
      if (i == 5) begin
        for (int j = 0; j < 25; j++) begin
          wcoef(39 + j, (j == 19) ? 16'h4000 : (j == 20) ? 16'h2000 : (j == 24) ? 16'h1000 : 16'h0);
          wcoef(7 + j, (j == 19) ? 16'h4000 : (j == 20) ? 16'h2000 : (j == 24) ? 16'h1000 : 16'h0);
        end
        @(negedge clk_in);
        coef_wr_in = 1'b0;
      end
      run(rb[i], rr[i]);
    end
    test_done();
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
